// ==== verilog/misc_ctrl_params.svh ====
// Offsets, field positions, reset values and timing counts of the control block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef MISC_CTRL_PARAMS_SVH
`define MISC_CTRL_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_WD_TRIM       8'hF7
`define IDX_MISC_CTRL     8'hF8
`define IDX_OPTION_VIEW   8'hF9
`define IDX_STATUS_VIEW   8'hFA

// Watchdog and trim register fields
`define WDEN_HI           7
`define WDEN_LO           6
`define TRIM_HI           4
`define TRIM_LO           0
`define WDEN_RST          2'h0

// Misc control register fields
`define BIT_WD_CLR        7
`define BIT_T3_CLR        6
`define BIT_TOUCH_START   5
`define BIT_ADC_START     4
`define BIT_PWM0_HOLD     3
`define BIT_PTR_SEL       0
`define MISC_RST          8'h00

// Option byte (upper) fields
`define OPT_CODE_LOCK     7
`define OPT_XRST          6
`define OPT_BOR_HI        5
`define OPT_BOR_LO        4
`define OPT_FILT          3
`define OPT_SAVE          2
`define OPT_TBLLOCK       1

// Start-up: cycles the option bytes need through the synchroniser
`define OPT_LOAD_CYCLES   3'h4

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

`endif

// ==== verilog/misc_ctrl_pkg.sv ====
// Types shared by the control block.
// Assumes the params header sits beside it.
`include "misc_ctrl_params.svh"
package misc_ctrl_pkg;
  // Start-up sequencer states
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN  = 2'b01
  } boot_state_t;
  // Decoded brownout setting
  typedef enum logic [1:0] {
    BOR_29     = 2'b00,
    BOR_23     = 2'b01,
    BOR_OFF    = 2'b10,
    BOR_18_DET = 2'b11
  } bor_sel_t;
endpackage

// ==== verilog/misc_ctrl.sv ====
// Miscellaneous control registers and start-up option latches of a small micro.
// Assumes an AXI4-Lite master on aclk, option bytes and reset pin from outside.
// Operation
// - Watchdog reset enable sits in bits 7..6; upper bit zero keeps watchdog reset off.
// - Field value 10 allows watchdog reset in fast or slow mode, not in idle or stop.
// - A five-bit fast oscillator trim in bits 4..0, seeded from option byte 1FFEh.
// - Writing one to bit 7 restarts the watchdog and the bit clears the next cycle.
// - Writing one to bit 6 clears timer3 and the bit clears the next cycle.
// - Touch start launches a conversion, cleared by done or by software writing zero.
// - ADC start in bit 4 launches a conversion, cleared by done or by writing zero.
// - PWM0 hold in bit 3 clears and holds the PWM counter while one.
// - Option bit 7 of 1FFFh enables code protection when one.
// - Option bit 6 enables the external reset pin; when zero the pin does nothing (the status view still shows the pin in bit 1).
// - Option bits 5..4 pick brownout reset level and detect as encoded.
// - Option bit 2 enables power saving when one.
// - Option bit 1 restricts table reads and external moves into the locked area.
//
// Our own choice: the AXI4-Lite register port.
`include "misc_ctrl_params.svh"

module misc_ctrl
  import misc_ctrl_pkg::*;
(
  input  wire logic        aclk,                // System clock
  input  wire logic        aresetn,             // Sync reset, active low
  input  wire logic [11:0] s_axi_awaddr,        // Write address
  input  wire logic        s_axi_awvalid,       // Write address valid
  output logic             s_axi_awready,       // Write address ready
  input  wire logic [31:0] s_axi_wdata,         // Write data
  input  wire logic [3:0]  s_axi_wstrb,         // Write strobes
  input  wire logic        s_axi_wvalid,        // Write data valid
  output logic             s_axi_wready,        // Write data ready
  output logic [1:0]       s_axi_bresp,         // Write response
  output logic             s_axi_bvalid,        // Write response valid
  input  wire logic        s_axi_bready,        // Write response ready
  input  wire logic [11:0] s_axi_araddr,        // Read address
  input  wire logic        s_axi_arvalid,       // Read address valid
  output logic             s_axi_arready,       // Read address ready
  output logic [31:0]      s_axi_rdata,         // Read data
  output logic [1:0]       s_axi_rresp,         // Read response
  output logic             s_axi_rvalid,        // Read data valid
  input  wire logic        s_axi_rready,        // Read data ready
  input  wire logic [7:0]  option_trim_byte,    // Flash byte 1FFEh
  input  wire logic [7:0]  option_cfg_byte,     // Flash byte 1FFFh
  input  wire logic        ext_reset_pin_n,     // External reset pin, active low
  input  wire logic        low_power_mode,      // Core in idle or stop
  input  wire logic        watchdog_overflow,   // Watchdog expired pulse
  input  wire logic        touch_done,          // Touch conversion finished
  input  wire logic        adc_done,            // ADC conversion finished
  output logic             core_run,            // Core may execute
  output logic             watchdog_reset_req,  // Reset from watchdog
  output logic             ext_reset_req,       // Reset from pin
  output logic [4:0]       fast_osc_trim,       // Oscillator trim
  output logic             watchdog_clear,      // Watchdog restart pulse
  output logic             timer3_clear,        // Timer3 clear pulse
  output logic             touch_convert_start, // Touch conversion running
  output logic             adc_convert_start,   // ADC conversion running
  output logic             first_pwm_clear_hold,// PWM0 held in clear
  output logic             pointer_select,      // Active data pointer
  output logic             code_read_lock,      // Code protection on
  output logic             brownout_reset_en,   // Brownout reset on
  output logic [1:0]       brownout_reset_level,// 0 2.9V, 1 2.3V, 3 1.8V
  output logic             brownout_detect_en,  // Detect at 2.3V on
  output logic             supply_noise_filter, // Supply filter on
  output logic             power_saving_enable, // Power saving on
  output logic             table_read_lock      // Locked area restricted
);

  // ****************************************
  // Start-up option loading
  // ****************************************

  logic [7:0]  opt_trim_s1_r;
  logic [7:0]  opt_trim_s2_r;
  logic [7:0]  opt_cfg_s1_r;
  logic [7:0]  opt_cfg_s2_r;
  logic [7:0]  opt_cfg_r;
  logic [2:0]  load_cnt_r;
  boot_state_t boot_r;
  logic        rst_s1_r;
  logic        rst_s2_r;

  // Two-stage synchronisers; flash bytes and pin are foreign to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opt_trim_s1_r <= 8'h00;
      opt_trim_s2_r <= 8'h00;
      opt_cfg_s1_r  <= 8'h00;
      opt_cfg_s2_r  <= 8'h00;
      rst_s1_r      <= 1'b1;
      rst_s2_r      <= 1'b1;
    end else begin
      opt_trim_s1_r <= option_trim_byte;
      opt_trim_s2_r <= opt_trim_s1_r;
      opt_cfg_s1_r  <= option_cfg_byte;
      opt_cfg_s2_r  <= opt_cfg_s1_r;
      rst_s1_r      <= ext_reset_pin_n;
      rst_s2_r      <= rst_s1_r;
    end
  end

  // Hold the core until the synchronised bytes are settled, then latch once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_r     <= ST_LOAD;
      load_cnt_r <= 3'h0;
      opt_cfg_r  <= 8'h00;
      core_run   <= 1'b0;
    end else begin
      case (boot_r)
        ST_LOAD: begin
          load_cnt_r <= load_cnt_r + 3'h1;
          if (load_cnt_r == `OPT_LOAD_CYCLES) begin
            opt_cfg_r <= opt_cfg_s2_r;
            boot_r    <= ST_RUN;
            core_run  <= 1'b1;
          end
        end
        ST_RUN: begin
          boot_r <= ST_RUN;
        end
        default: begin
          boot_r <= ST_LOAD;
        end
      endcase
    end
  end

  // Option-driven outputs, each from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_read_lock       <= 1'b0;
      brownout_reset_en    <= 1'b0;
      brownout_reset_level <= 2'h0;
      brownout_detect_en   <= 1'b0;
      supply_noise_filter  <= 1'b0;
      power_saving_enable  <= 1'b0;
      table_read_lock      <= 1'b0;
      ext_reset_req        <= 1'b0;
    end else begin
      code_read_lock      <= opt_cfg_r[`OPT_CODE_LOCK];
      supply_noise_filter <= opt_cfg_r[`OPT_FILT];
      power_saving_enable <= opt_cfg_r[`OPT_SAVE];
      table_read_lock     <= opt_cfg_r[`OPT_TBLLOCK];
      ext_reset_req       <= opt_cfg_r[`OPT_XRST] & ~rst_s2_r;
      case (bor_sel_t'(opt_cfg_r[`OPT_BOR_HI:`OPT_BOR_LO]))
        BOR_29: begin
          brownout_reset_en <= 1'b1; brownout_reset_level <= 2'h0; brownout_detect_en <= 1'b0;
        end
        BOR_23: begin
          brownout_reset_en <= 1'b1; brownout_reset_level <= 2'h1; brownout_detect_en <= 1'b0;
        end
        BOR_OFF: begin
          brownout_reset_en <= 1'b0; brownout_reset_level <= 2'h0; brownout_detect_en <= 1'b1;
        end
        default: begin
          brownout_reset_en <= 1'b1; brownout_reset_level <= 2'h3; brownout_detect_en <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************

  logic [11:0] aw_addr_r;
  logic        aw_held_r;
  logic [31:0] w_data_r;
  logic        w_strb0_r;
  logic        w_held_r;
  logic        wr_fire;
  logic [9:0]  wr_idx;
  logic [9:0]  rd_idx;
  logic        wr_byte0;

  // One write at a time: take each channel once, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 12'h000;
      w_data_r      <= 32'h0000_0000;
      w_strb0_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid;
      s_axi_wready  <= ~w_held_r & ~s_axi_wready & ~s_axi_bvalid & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r  <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx >= {2'h0, `IDX_WD_TRIM} && wr_idx <= {2'h0, `IDX_STATUS_VIEW}
                         && aw_addr_r[1:0] == 2'h0) ? `RESP_OKAY : `RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_fire  = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_idx   = aw_addr_r[11:2];
  assign rd_idx   = s_axi_araddr[11:2];
  // Only byte lane 0 carries the 8-bit registers; views are read-only
  assign wr_byte0 = wr_fire & w_strb0_r & (aw_addr_r[1:0] == 2'h0);

  // ****************************************
  // Control registers
  // ****************************************

  logic [1:0] wd_en_r;
  logic [4:0] trim_r;
  logic       trim_seed_r;
  logic       wr_trim;
  logic       wr_misc;

  assign wr_trim = wr_byte0 & (wr_idx == {2'h0, `IDX_WD_TRIM});
  assign wr_misc = wr_byte0 & (wr_idx == {2'h0, `IDX_MISC_CTRL});

  // Watchdog enable and trim; trim seeded once from the option byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_en_r     <= `WDEN_RST;
      trim_r      <= 5'h00;
      trim_seed_r <= 1'b0;
    end else begin
      if (boot_r == ST_LOAD && load_cnt_r == `OPT_LOAD_CYCLES) begin
        trim_r      <= opt_trim_s2_r[`TRIM_HI:`TRIM_LO];
        trim_seed_r <= 1'b1;
      end else if (wr_trim) begin
        wd_en_r <= w_data_r[`WDEN_HI:`WDEN_LO];
        trim_r <= w_data_r[`TRIM_HI:`TRIM_LO];
      end
    end
  end

  // Watchdog reset gating; 11 treated as enabled in every mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_reset_req <= 1'b0;
      fast_osc_trim      <= 5'h00;
    end else begin
      fast_osc_trim      <= trim_r;
      watchdog_reset_req <= watchdog_overflow & wd_en_r[1]
                            & (wd_en_r[0] | ~low_power_mode);
    end
  end

  // Pulse bits clear next cycle; software set beats a done in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_clear       <= 1'b0;
      timer3_clear         <= 1'b0;
      touch_convert_start  <= 1'b0;
      adc_convert_start    <= 1'b0;
      first_pwm_clear_hold <= 1'b0;
      pointer_select       <= 1'b0;
    end else begin
      watchdog_clear <= wr_misc & w_data_r[`BIT_WD_CLR];
      timer3_clear   <= wr_misc & w_data_r[`BIT_T3_CLR];
      if (wr_misc) begin
        touch_convert_start  <= w_data_r[`BIT_TOUCH_START];
        adc_convert_start    <= w_data_r[`BIT_ADC_START];
        first_pwm_clear_hold <= w_data_r[`BIT_PWM0_HOLD];
        pointer_select       <= w_data_r[`BIT_PTR_SEL];
      end
      if (touch_done && !(wr_misc && w_data_r[`BIT_TOUCH_START])) begin
        touch_convert_start <= 1'b0;
      end
      if (adc_done && !(wr_misc && w_data_r[`BIT_ADC_START])) begin
        adc_convert_start <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  logic [7:0] rd_byte;
  logic       rd_hit;

  // Read mux; misc view shows live state including pulse bits
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (rd_idx)
      {2'h0, `IDX_WD_TRIM}:     rd_byte = {wd_en_r, 1'b0, trim_r};
      {2'h0, `IDX_MISC_CTRL}:   rd_byte = {watchdog_clear, timer3_clear, touch_convert_start,
                                           adc_convert_start, first_pwm_clear_hold, 2'h0,
                                           pointer_select};
      {2'h0, `IDX_OPTION_VIEW}: rd_byte = opt_cfg_r;
      {2'h0, `IDX_STATUS_VIEW}: rd_byte = {5'h00, trim_seed_r, ~rst_s2_r, core_run};
      default:                  rd_hit  = 1'b0;
    endcase
    if (s_axi_araddr[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end
  end

  // One read at a time; data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? {24'h000000, rd_byte} : 32'h0000_0000;
        s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ==== tb/misc_ctrl_props.sv ====
// Port checker for the misc control block.
// Assumes option bytes change only while aresetn is low.
// ****************
// Checker
// ****************
module misc_ctrl_props (
  input wire logic       aclk,                 // Clock
  input wire logic       aresetn,              // Reset, low
  input wire logic       s_axi_bvalid,         // Resp valid
  input wire logic       s_axi_bready,         // Resp ready
  input wire logic [1:0] s_axi_bresp,          // Resp code
  input wire logic [7:0] option_cfg_byte,      // Option byte
  input wire logic       watchdog_overflow,    // Expiry
  input wire logic       adc_done,             // ADC end
  input wire logic       core_run,             // Run
  input wire logic       watchdog_reset_req,   // Watchdog reset
  input wire logic       ext_reset_req,        // Pin reset
  input wire logic       watchdog_clear,       // Watchdog pulse
  input wire logic       timer3_clear,         // T3 pulse
  input wire logic       touch_convert_start,  // Touch busy
  input wire logic       adc_convert_start,    // ADC busy
  input wire logic       first_pwm_clear_hold, // PWM hold
  input wire logic       pointer_select,       // Pointer
  input wire logic       code_read_lock,       // Protect
  input wire logic       brownout_detect_en,   // Detect
  input wire logic       power_saving_enable,  // Save
  input wire logic       table_read_lock       // Lock
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so one default
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wd_pulse;
    watchdog_clear |=> !watchdog_clear;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog clear long");
  property p_t3_pulse;
    timer3_clear |=> !timer3_clear;
  endproperty
  a_t3_pulse: assert property (p_t3_pulse) else $error("t3 clear long");
  property p_wd_cause;
    watchdog_reset_req |-> $past(watchdog_overflow);
  endproperty
  a_wd_cause: assert property (p_wd_cause) else $error("watchdog reset uncaused");
  property p_ext_gate;
    ext_reset_req |-> option_cfg_byte[6];
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("pin reset not enabled");
  property p_touch_set;
    $rose(touch_convert_start) |-> $rose(s_axi_bvalid);
  endproperty
  a_touch_set: assert property (p_touch_set) else $error("touch start unwritten");
  // A write in the done cycle may set the bit again
  property p_adc_end;
    adc_done |=> !adc_convert_start || $rose(s_axi_bvalid);
  endproperty
  a_adc_end: assert property (p_adc_end) else $error("adc start not cleared");
  property p_hold_ptr;
    $changed({first_pwm_clear_hold, pointer_select}) |-> $rose(s_axi_bvalid);
  endproperty
  a_hold_ptr: assert property (p_hold_ptr) else $error("hold or ptr moved");
  property p_opt_load;
    $rose(core_run) |-> !code_read_lock ##1 code_read_lock == option_cfg_byte[7];
  endproperty
  a_opt_load: assert property (p_opt_load) else $error("protect not loaded");
  property p_opt_hold;
    core_run && $past(core_run) |-> brownout_detect_en == option_cfg_byte[5]
      && power_saving_enable == option_cfg_byte[2] && table_read_lock == option_cfg_byte[1];
  endproperty
  a_opt_hold: assert property (p_opt_hold) else $error("option outputs wrong");
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write resp dropped");
  c_wd_reset: cover property ($rose(watchdog_reset_req));
  c_decerr: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
  c_adc: cover property ($fell(adc_convert_start));
endmodule

bind misc_ctrl misc_ctrl_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .option_cfg_byte, .watchdog_overflow, .adc_done, .core_run,
  .watchdog_reset_req, .ext_reset_req, .watchdog_clear, .timer3_clear, .touch_convert_start,
  .adc_convert_start, .first_pwm_clear_hold, .pointer_select, .code_read_lock,
  .brownout_detect_en, .power_saving_enable, .table_read_lock);

// ==== tb/misc_ctrl_tb.sv ====
// Self-checking bench for the misc control block.
// Assumes the design and checker are compiled before it.
`include "misc_ctrl_params.svh"
module misc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals
  // ****************
  localparam logic [11:0] A_TRIM = {2'h0, `IDX_WD_TRIM, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, `IDX_STATUS_VIEW, 2'h0};
  localparam logic [11:0] A_MISC = {2'h0, `IDX_MISC_CTRL, 2'h0};
  localparam logic [11:0] A_OPT  = {2'h0, `IDX_OPTION_VIEW, 2'h0};
  logic        aclk = 1'b0;
  logic        aresetn, awv, wv, bready, arv, rready, ovf, lpm, tdone, adone, pin_n;
  logic        awr, wr, bv, arr, rv, run, wrq, xrq, wclr, tclr, tks, ads, pwm, psel;
  logic        rdlock, bre, bde, psv, tbl, flt;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [7:0]  trim_b, cb;
  logic [4:0]  trim;
  logic [1:0]  bresp, rresp, blv, p2;
  int          err_count = 0;
  int          n_compared = 0;

  misc_ctrl uut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .option_trim_byte(trim_b),
    .option_cfg_byte(cb), .ext_reset_pin_n(pin_n), .low_power_mode(lpm),
    .watchdog_overflow(ovf), .touch_done(tdone), .adc_done(adone), .core_run(run),
    .watchdog_reset_req(wrq), .ext_reset_req(xrq), .fast_osc_trim(trim),
    .watchdog_clear(wclr), .timer3_clear(tclr), .touch_convert_start(tks),
    .adc_convert_start(ads), .first_pwm_clear_hold(pwm), .pointer_select(psel),
    .code_read_lock(rdlock), .brownout_reset_en(bre), .brownout_reset_level(blv),
    .brownout_detect_en(bde), .supply_noise_filter(flt), .power_saving_enable(psv),
    .table_read_lock(tbl));

  // 100 MHz clock
  always #5 aclk = ~aclk;

  // ****************
  // Tasks
  // ****************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Write; pulses are caught at the response edge, the only cycle they stand
  task wchk(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= 32'(d);
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bready <= 1'b0;
    p2 = {wclr, tclr};
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task rchk(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rready <= 1'b0;
    chk("rresp", 32'(er), 32'(rresp));
    chk("rdata", 32'(e), rdata);
  endtask

  // Options may only change under reset
  task boot(input logic [7:0] c);
    @(posedge aclk);
    aresetn <= 1'b0;
    cb <= c;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 20 && run !== 1'b1; i++) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask

  // Hang guard, far above the expected run of a few hundred cycles
  initial begin
    repeat (8000) @(posedge aclk);
    err_count++;
    $display("timeout");
    end_sim();
  end

  // ****************
  // Tests
  // ****************
  initial begin
    {aresetn, awv, wv, bready, arv, rready, ovf, lpm, tdone, adone} = '0;
    {awaddr, araddr, wdata, cb} = '0;
    pin_n = 1'b1;
    wstrb = 4'hF;
    trim_b = 8'h15;
    for (int k = 0; k < 4; k++) begin
      boot({k[0], ~k[0], k[1:0], k[0], k[1], ~k[1], 1'b0});
      chk("core_run", 1, 32'(run));
      chk("read_lock", 32'(cb[7]), 32'(rdlock));
      chk("filter", 32'(cb[3]), 32'(flt));
      chk("bor", {k != 2, (k == 3) ? 2'h3 : {1'b0, k == 1}, k[1]}, {bre, blv, bde});
      chk("save_lock", 32'(cb[2:1]), {psv, tbl});
      rchk(A_OPT, cb, `RESP_OKAY);
      pin_n <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("pin_reset", 32'(cb[6]), 32'(xrq));
      rchk(A_STAT, 8'h07, `RESP_OKAY);
      pin_n <= 1'b1;
    end
    rchk(A_MISC, `MISC_RST, `RESP_OKAY);
    rchk(A_TRIM, 8'h15, `RESP_OKAY);
    chk("trim", 5'h15, 32'(trim));
    rchk(A_STAT, 8'h05, `RESP_OKAY);
    // Every enable code in both power modes
    for (int w = 0; w < 4; w++) begin
      for (int l = 0; l < 2; l++) begin
        wchk(A_TRIM, {w[1:0], 1'b0, 5'h0A}, `RESP_OKAY);
        lpm <= l[0];
        ovf <= 1'b1;
        @(posedge aclk);
        ovf <= 1'b0;
        @(posedge aclk);
        chk("wd_reset", (w == 2) ? 32'(!l[0]) : 32'(w == 3), 32'(wrq));
      end
    end
    lpm <= 1'b0;
    wchk(A_TRIM, 8'h9F, `RESP_OKAY);
    rchk(A_TRIM, 8'h9F, `RESP_OKAY);
    chk("trim", 5'h1F, 32'(trim));
    wchk(A_MISC, 8'hC0, `RESP_OKAY);
    chk("pulses", 2'b11, 32'(p2));
    rchk(A_MISC, 8'h00, `RESP_OKAY);
    wchk(A_MISC, 8'h39, `RESP_OKAY);
    chk("levels", 6'h0F, {p2, tks, ads, pwm, psel});
    adone <= 1'b1;
    @(posedge aclk);
    adone <= 1'b0;
    rchk(A_MISC, 8'h29, `RESP_OKAY);
    tdone <= 1'b1;
    @(posedge aclk);
    tdone <= 1'b0;
    rchk(A_MISC, 8'h09, `RESP_OKAY);
    wchk(A_MISC, 8'h20, `RESP_OKAY);
    wchk(A_MISC, 8'h00, `RESP_OKAY);
    chk("cleared", 0, {tks, pwm, psel});
    // Unmapped, unaligned and read-only places
    wchk(12'h3EC, 8'hFF, `RESP_DECERR);
    wchk(12'h3DD, 8'h00, `RESP_DECERR);
    rchk(12'h3F0, 8'h00, `RESP_DECERR);
    wchk(A_OPT, 8'h00, `RESP_OKAY);
    rchk(A_OPT, cb, `RESP_OKAY);
    rchk(A_TRIM, 8'h9F, `RESP_OKAY);
    end_sim();
  end
endmodule
